/* File: include/xfer_exec_pkg.sv */
// Constants and types for the data transfer instruction executor
package xfer_exec_pkg;
	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 16;
	localparam int          DISP_W      = 6;
	localparam int          STORE_CYC   = 2;
	localparam int          PMLOAD_CYC  = 3;
	localparam int          STACK_CYC   = 2;
	localparam int          CTRL_CYC    = 1;
	localparam logic [1:0]  CNT_ONE     = 2'h1;
	localparam logic [15:0] PTR_STEP    = 16'h0001;
	localparam logic [15:0] PTR_RESET   = 16'h0000;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	// Pointer pair selectors
	localparam logic [1:0]  PTR_X       = 2'h0;
	localparam logic [1:0]  PTR_Y       = 2'h1;
	localparam logic [1:0]  PTR_Z       = 2'h2;
	// Pointer update modes for indirect stores and program loads
	localparam logic [1:0]  MODE_PLAIN  = 2'h0;
	localparam logic [1:0]  MODE_POSTINC = 2'h1;
	localparam logic [1:0]  MODE_PREDEC = 2'h2;

	// Operation codes from the core sequencer
	typedef enum logic [3:0] {
		OP_NONE              = 4'h0,
		OP_STORE_INDIRECT    = 4'h1,
		OP_STORE_DISPLACED   = 4'h2,
		OP_STORE_DIRECT      = 4'h3,
		OP_PROGMEM_LOAD      = 4'h4,
		OP_PROGMEM_STORE     = 4'h5,
		OP_PUSH              = 4'h6,
		OP_POP               = 4'h7,
		OP_SLEEP             = 4'h8,
		OP_WATCHDOG_RESTART  = 4'h9,
		OP_BREAK             = 4'hA
	} op_e;

	// Execution states, Gray along idle-exec1-exec2
	typedef enum logic [1:0] {
		SQ_IDLE  = 2'b00,
		SQ_EXEC1 = 2'b01,
		SQ_EXEC2 = 2'b11
	} exec_state_e;
endpackage : xfer_exec_pkg

/* File: tb/test_data_transfer_insn_exec.sv */
// Self-checking bench for the transfer executor
`timescale 1ns/10ps
`default_nettype none
module test_data_transfer_insn_exec;
	import xfer_exec_pkg::*;
	logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, op_valid = 1'b0, debug_enable = 1'b0;
	logic [3:0] op_code = 4'h0;
	logic [1:0] ptr_sel = 2'h0, ptr_mode = 2'h0, ptr_wsel;
	logic [5:0] disp = 6'h3F;
	logic [15:0] imm_addr = 16'h8001, ptr_x = 16'hFFFF, ptr_y = 16'h0100, ptr_z = 16'h1234;
	logic [7:0] src_data = 8'hA5, work_reg_lo = 8'h3C, work_reg_hi = 8'hC3;
	logic [7:0] pm_rdata, stack_rdata, dm_wdata, stack_wdata, rd_data;
	logic op_ready, op_done, dm_we, pm_re, pm_we, stack_push, stack_pop, rd_we, ptr_we;
	logic sleep_req, wdt_restart, debug_break, flags_we;
	logic [15:0] dm_addr, pm_addr, ptr_wdata, pm_wdata, pmw;
	int err_total = 0, checks = 0;
	data_transfer_insn_exec data_transfer_insn_exec_i (.*);
	xfer_mem_model xfer_mem_model_i (.*);
	initial forever #25 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	// Issue one request, wait for completion, count edges
	task automatic run(input logic [3:0] c, input logic [1:0] s, input logic [1:0] m, input int n);
		int k;
		k = 0;
		pmw = 16'h0000;
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= c;
		ptr_sel <= s;
		ptr_mode <= m;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		// Take cycle counts as the first cycle
		#1;
		k = 1;
		while (op_done !== 1'b1 && k < 6) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		if (pm_we === 1'b1) pmw = pm_wdata;
		if (n > 0) chk("cycles", n, k);
	endtask : run
	task automatic t_store;
		run(OP_STORE_INDIRECT, PTR_X, MODE_POSTINC, 2);
		chk("dm_addr", ptr_x, dm_addr);
		chk("dm_wdata", src_data, dm_wdata);
		chk("ptr_wdata", ptr_x + PTR_STEP, ptr_wdata);
		run(OP_STORE_INDIRECT, PTR_Y, MODE_PREDEC, 2);
		chk("dm_addr", ptr_y - PTR_STEP, dm_addr);
		chk("ptr_wsel", PTR_Y, ptr_wsel);
		run(OP_STORE_DISPLACED, PTR_Z, MODE_PLAIN, 2);
		chk("dm_addr", ptr_z + disp, dm_addr);
		run(OP_STORE_DIRECT, PTR_X, MODE_PLAIN, 2);
		chk("dm_addr", imm_addr, dm_addr);
		$display("store test done");
	endtask : t_store
	task automatic t_prog;
		run(OP_PROGMEM_LOAD, PTR_Z, MODE_POSTINC, 3);
		chk("rd_data", ptr_z[7:0] ^ 8'h5A, rd_data);
		chk("ptr_wdata", ptr_z + PTR_STEP, ptr_wdata);
		run(OP_PROGMEM_STORE, PTR_Z, MODE_PLAIN, 0);
		chk("pm_wdata", {work_reg_hi, work_reg_lo}, pmw);
		chk("pm_addr", ptr_z, pm_addr);
		$display("program memory test done");
	endtask : t_prog
	task automatic t_stack;
		run(OP_PUSH, PTR_X, MODE_PLAIN, 2);
		chk("stack_wdata", src_data, stack_wdata);
		run(OP_POP, PTR_X, MODE_PLAIN, 2);
		chk("rd_data", src_data, rd_data);
		$display("stack test done");
	endtask : t_stack
	task automatic t_ctrl;
		run(OP_SLEEP, PTR_X, MODE_PLAIN, 1);
		chk("sleep_req", 1'b1, sleep_req);
		run(OP_WATCHDOG_RESTART, PTR_X, MODE_PLAIN, 1);
		chk("wdt_restart", 1'b1, wdt_restart);
		run(OP_BREAK, PTR_X, MODE_PLAIN, 1);
		chk("debug_break", 1'b0, debug_break);
		debug_enable <= 1'b1;
		run(OP_BREAK, PTR_X, MODE_PLAIN, 1);
		chk("debug_break", 1'b1, debug_break);
		chk("flags_we", 1'b0, flags_we);
		$display("control test done");
	endtask : t_ctrl
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_store;
		t_prog;
		t_stack;
		t_ctrl;
		tally_and_finish;
	end
	// Hang guard
	initial begin
		repeat (2000) @(posedge ref_clk);
		err_total++;
		tally_and_finish;
	end
endmodule : test_data_transfer_insn_exec
`default_nettype wire

/* File: tb/xfer_exec_assertions.sv */
// Port checks for the transfer executor
`timescale 1ns/10ps
`default_nettype none
module xfer_exec_assertions
	import xfer_exec_pkg::*;
(
	input wire logic	ref_clk, reset_n, op_valid, op_ready, op_done, dm_we,
	input wire logic	ptr_we, rd_we, stack_push, sleep_req, wdt_restart, flags_we,
	input wire logic [3:0]	op_code,
	input wire logic [1:0]	ptr_sel, ptr_mode,
	input wire logic [5:0]	disp,
	input wire logic [15:0]	imm_addr, ptr_x, ptr_y, ptr_z, dm_addr, ptr_wdata
);
	// Pointer picked by the request
	wire logic [15:0] p = (ptr_sel == PTR_X) ? ptr_x : (ptr_sel == PTR_Y) ? ptr_y : ptr_z;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence take_s(logic [3:0] c); op_valid && op_ready && op_code == c; endsequence
	sequence ind_s(logic [1:0] m); take_s(OP_STORE_INDIRECT) ##0 ptr_mode == m; endsequence
	postinc_a: assert property (ind_s(MODE_POSTINC) |=> !op_done ##1 op_done &&
		dm_addr == $past(p, 2) && ptr_wdata == $past(p, 2) + 16'h0001) else $error("post-inc");
	predec_a: assert property (ind_s(MODE_PREDEC) |-> ##2 dm_we &&
		dm_addr == $past(p, 2) - 16'h0001 && ptr_wdata == dm_addr) else $error("pre-dec");
	disp_store_a: assert property (take_s(OP_STORE_DISPLACED) |-> ##2 dm_we && !ptr_we &&
		dm_addr == $past(p, 2) + $past(disp, 2)) else $error("displaced store");
	direct_store_a: assert property (take_s(OP_STORE_DIRECT) |-> ##2 dm_we && op_done &&
		dm_addr == $past(imm_addr, 2)) else $error("direct store");
	pm_load_a: assert property (take_s(OP_PROGMEM_LOAD) |=> !rd_we [*2] ##1 rd_we && op_done)
		else $error("program load timing");
	push_a: assert property (take_s(OP_PUSH) |=> !stack_push ##1 stack_push && op_done)
		else $error("push timing");
	pop_a: assert property (take_s(OP_POP) |=> !rd_we ##1 rd_we && op_done)
		else $error("pop timing");
	sleep_a: assert property (take_s(OP_SLEEP) |=> sleep_req && op_done)
		else $error("sleep timing");
	wdt_a: assert property (take_s(OP_WATCHDOG_RESTART) |=> wdt_restart ##1 !wdt_restart)
		else $error("watchdog pulse");
	flags_kept_a: assert property (flags_we == 1'b0)
		else $error("flags written");
endmodule : xfer_exec_assertions
bind data_transfer_insn_exec xfer_exec_assertions xfer_exec_assertions_i (.*);
`default_nettype wire

/* File: tb/xfer_mem_model.sv */
// Behavioural stack and program memory on the far side
`timescale 1ns/10ps
`default_nettype none
module xfer_mem_model
	import xfer_exec_pkg::*;
(
	input wire logic		ref_clk, pm_re, stack_push, stack_pop,
	input wire logic [15:0]	pm_addr,
	input wire logic [7:0]	stack_wdata,
	output logic [7:0]		pm_rdata, stack_rdata
);
	logic [7:0] stk [0:7];
	logic [2:0] sp_reg = 3'h0;
	logic [7:0] last_reg = 8'h00;
	// Byte shown only while read strobe stands, else toggling junk
	assign pm_rdata = pm_re ? (pm_addr[7:0] ^ 8'h5A) : ~last_reg;
	assign stack_rdata = stk[sp_reg - 3'h1];
	always @(posedge ref_clk) begin
		last_reg <= pm_rdata;
		if (stack_push) stk[sp_reg] <= stack_wdata;
		if (stack_push) sp_reg <= sp_reg + 3'h1;
		if (stack_pop) sp_reg <= sp_reg - 3'h1;
	end
endmodule : xfer_mem_model
`default_nettype wire

/* File: verilog/data_transfer_insn_exec.sv */
// Executor for stores, program memory access, stack and control instructions
//
// Overview of operation
// - Post-increment store writes at pointer, then adds one; two cycles, flags kept.
// - Pre-decrement store subtracts one first, then writes; two cycles, flags kept.
// - Displaced store writes at the selected pointer (X, Y or Z) plus offset; pointer kept; two cycles.
// - Direct store writes at immediate address; two cycles, flags kept.
// - Program load reads byte at Z into destination, optional post-increment; three cycles.
// - Program store writes work_reg_hi:work_reg_lo word at Z, flags kept.
// - Push places source register on the stack; two cycles, flags kept.
// - Pop loads destination register from stack top; two cycles, flags kept.
// - Sleep issues in one cycle and hands over to sleep logic.
// - Watchdog restart takes one cycle and pulses the watchdog restart.
// - Break acts only for on-chip debug; no flag change.
`timescale 1ns/10ps
`default_nettype none
module data_transfer_insn_exec
	import xfer_exec_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	input  wire logic              op_valid,
	input  wire logic [3:0]        op_code,
	input  wire logic [1:0]        ptr_sel,
	input  wire logic [1:0]        ptr_mode,
	input  wire logic [DISP_W-1:0] disp,
	input  wire logic [ADDR_W-1:0] imm_addr,
	input  wire logic [DATA_W-1:0] src_data,
	input  wire logic [ADDR_W-1:0] ptr_x,
	input  wire logic [ADDR_W-1:0] ptr_y,
	input  wire logic [ADDR_W-1:0] ptr_z,
	input  wire logic [DATA_W-1:0] work_reg_lo,
	input  wire logic [DATA_W-1:0] work_reg_hi,
	input  wire logic [DATA_W-1:0] pm_rdata,
	input  wire logic [DATA_W-1:0] stack_rdata,
	input  wire logic              debug_enable,
	output logic                   op_ready,
	output logic                   op_done,
	output logic                   dm_we,
	output logic      [ADDR_W-1:0] dm_addr,
	output logic      [DATA_W-1:0] dm_wdata,
	output logic                   pm_re,
	output logic                   pm_we,
	output logic      [ADDR_W-1:0] pm_addr,
	output logic      [15:0]       pm_wdata,
	output logic                   stack_push,
	output logic                   stack_pop,
	output logic      [DATA_W-1:0] stack_wdata,
	output logic                   rd_we,
	output logic      [DATA_W-1:0] rd_data,
	output logic                   ptr_we,
	output logic      [1:0]        ptr_wsel,
	output logic      [ADDR_W-1:0] ptr_wdata,
	output logic                   sleep_req,
	output logic                   wdt_restart,
	output logic                   debug_break,
	output logic                   flags_we
);
	exec_state_e       state_reg, state_next;
	logic [3:0]        op_reg;
	logic [1:0]        sel_reg, mode_reg;
	logic [ADDR_W-1:0] addr_reg, ptr_new_reg;
	logic [DATA_W-1:0] data_reg;
	logic [15:0]       word_reg;

	// Decode of incoming request
	wire               take       = clk_en && op_valid && (state_reg == SQ_IDLE);
	wire [ADDR_W-1:0]  ptr_cur    = (ptr_sel == PTR_X) ? ptr_x :
	                                (ptr_sel == PTR_Y) ? ptr_y : ptr_z;
	wire               is_predec  = (op_code == OP_STORE_INDIRECT) && (ptr_mode == MODE_PREDEC);
	wire               is_postinc = (ptr_mode == MODE_POSTINC) &&
	                                ((op_code == OP_STORE_INDIRECT) ||
	                                 (op_code == OP_PROGMEM_LOAD));
	wire [ADDR_W-1:0]  ptr_stepped;
	wire [ADDR_W-1:0]  disp_addr  = ptr_cur + {{(ADDR_W-DISP_W){1'b0}}, disp};
	wire [ADDR_W-1:0]  eff_addr   =
		(op_code == OP_STORE_DIRECT)    ? imm_addr :
		(op_code == OP_STORE_DISPLACED) ? disp_addr :
		(op_code == OP_PROGMEM_LOAD)    ? ptr_z :
		(op_code == OP_PROGMEM_STORE)   ? ptr_z :
		is_predec                       ? ptr_stepped : ptr_cur;
	wire               multi      = (op_code == OP_STORE_INDIRECT) ||
	                                (op_code == OP_STORE_DISPLACED) ||
	                                (op_code == OP_STORE_DIRECT) ||
	                                (op_code == OP_PROGMEM_LOAD) ||
	                                (op_code == OP_PROGMEM_STORE) ||
	                                (op_code == OP_PUSH) || (op_code == OP_POP);
	wire               three      = (op_code == OP_PROGMEM_LOAD);
	wire               op_sel_z   = (op_code == OP_PROGMEM_LOAD);
	wire [ADDR_W-1:0]  step_base  = op_sel_z ? ptr_z : ptr_cur;

	ptr_step ptr_step_i (
		.ptr_in  (step_base),
		.dec     (is_predec),
		.ptr_out (ptr_stepped)
	);

	// State sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SQ_IDLE:  if (take && multi) state_next = three ? SQ_EXEC1 : SQ_EXEC2;
			SQ_EXEC1: state_next = SQ_EXEC2;
			SQ_EXEC2: state_next = SQ_IDLE;
			default:  state_next = SQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg <= SQ_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// Capture of operands when an instruction is taken
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			op_reg      <= OP_NONE;
			sel_reg     <= PTR_X;
			mode_reg    <= MODE_PLAIN;
			addr_reg    <= PTR_RESET;
			ptr_new_reg <= PTR_RESET;
			data_reg    <= BYTE_RESET;
			word_reg    <= PTR_RESET;
		end else if (take) begin
			op_reg      <= op_code;
			sel_reg     <= op_sel_z ? PTR_Z : ptr_sel;
			mode_reg    <= ptr_mode;
			addr_reg    <= eff_addr;
			ptr_new_reg <= ptr_stepped;
			data_reg    <= src_data;
			word_reg    <= {work_reg_hi, work_reg_lo};
		end
	end

	// Last-cycle actions of multi-cycle instructions
	wire last      = clk_en && (state_reg == SQ_EXEC2);
	wire ind_store = (op_reg == OP_STORE_INDIRECT);
	wire store_op  = ind_store || (op_reg == OP_STORE_DISPLACED) || (op_reg == OP_STORE_DIRECT);
	wire pm_load   = (op_reg == OP_PROGMEM_LOAD);
	wire upd_ptr   = (ind_store && (mode_reg != MODE_PLAIN)) ||
	                (pm_load && (mode_reg == MODE_POSTINC));

	// Single-cycle control instructions decode
	wire ctl_take = take && !multi;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dm_we       <= 1'b0;
			dm_addr     <= PTR_RESET;
			dm_wdata    <= BYTE_RESET;
			pm_re       <= 1'b0;
			pm_we       <= 1'b0;
			pm_addr     <= PTR_RESET;
			pm_wdata    <= PTR_RESET;
			stack_push  <= 1'b0;
			stack_pop   <= 1'b0;
			stack_wdata <= BYTE_RESET;
			rd_we       <= 1'b0;
			rd_data     <= BYTE_RESET;
			ptr_we      <= 1'b0;
			ptr_wsel    <= PTR_X;
			ptr_wdata   <= PTR_RESET;
			sleep_req   <= 1'b0;
			wdt_restart <= 1'b0;
			debug_break <= 1'b0;
			op_done     <= 1'b0;
		end else if (clk_en) begin
			dm_we       <= last && store_op;
			dm_addr     <= addr_reg;
			dm_wdata    <= data_reg;
			pm_re       <= (state_reg == SQ_EXEC1) && pm_load;
			pm_we       <= last && (op_reg == OP_PROGMEM_STORE);
			pm_addr     <= addr_reg;
			pm_wdata    <= word_reg;
			stack_push  <= last && (op_reg == OP_PUSH);
			stack_pop   <= last && (op_reg == OP_POP);
			stack_wdata <= data_reg;
			rd_we       <= last && (pm_load || (op_reg == OP_POP));
			rd_data     <= pm_load ? pm_rdata : stack_rdata;
			ptr_we      <= last && upd_ptr;
			ptr_wsel    <= sel_reg;
			ptr_wdata   <= ptr_new_reg;
			sleep_req   <= ctl_take && (op_code == OP_SLEEP);
			wdt_restart <= ctl_take && (op_code == OP_WATCHDOG_RESTART);
			debug_break <= ctl_take && (op_code == OP_BREAK) && debug_enable;
			op_done     <= last || ctl_take;
		end
	end

	// Handshake and flag protection
	assign op_ready = clk_en && (state_reg == SQ_IDLE);
	assign flags_we = 1'b0;
endmodule : data_transfer_insn_exec
`default_nettype wire

/* File: verilog/ptr_step.sv */
// Full-width pointer step unit, wraps modulo 65536
`timescale 1ns/10ps
`default_nettype none
module ptr_step
	import xfer_exec_pkg::*;
(
	input  wire logic [ADDR_W-1:0] ptr_in,
	input  wire logic              dec,
	output logic      [ADDR_W-1:0] ptr_out
);
	// Sixteen-bit add or subtract; carry passes between bytes
	assign ptr_out = dec ? ptr_in - PTR_STEP : ptr_in + PTR_STEP;
endmodule : ptr_step
`default_nettype wire
